// ==== logic/sep_cycle_timer.sv ====
`default_nettype none

module sep_cycle_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic start,
  output logic done
);
  import sep_pkg::*;

  typedef struct packed {
    logic [23:0] cnt;
    logic run;
    logic done;
  } sep_timer_s;

  sep_timer_s q, d;

  always_comb begin
    d = q;
    if (clkEn) begin
      d.done = 1'b0;
      if (start) begin
        d.run = 1'b1;
        d.cnt = 24'(CYCLES - 1);
      end else if (q.run) begin
        if (q.cnt == 24'h000000) begin
          d.run = 1'b0;
          d.done = 1'b1;
        end else begin
          d.cnt = q.cnt - 24'h000001;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
endmodule

`default_nettype wire

// ==== logic/sep_link.sv ====
`default_nettype none

module sep_link (
  input wire logic sck,
  input wire logic reset,
  input wire logic csN,
  input wire logic si,
  output logic so,
  output logic soEn,
  sep_link_if.link lnk
);
  import sep_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic [14:0] sh;
    logic [7:0] stMeta;
    logic [7:0] stSync;
  } sep_frame_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dataByte;
    logic [11:0] addr;
    logic [5:0] lastCnt;
    logic dataSeen;
    logic frameTog;
  } sep_cap_s;

  typedef struct packed {
    logic so;
    logic soEn;
    logic [7:0] snap;
  } sep_out_s;

  sep_frame_s fr_q, fr_d;
  sep_cap_s cap_q, cap_d;
  sep_out_s out_q, out_d;
  logic frameRst;
  logic [15:0] word16;

  // frame state ends with the frame's own select
  assign frameRst = reset | csN;
  assign word16 = {fr_q.sh, si};

  always_comb begin
    fr_d = fr_q;
    cap_d = cap_q;
    fr_d.sh = word16[14:0];
    fr_d.stMeta = lnk.statusWord;
    fr_d.stSync = fr_q.stMeta;
    if (fr_q.cnt == CNT_WRAP_TOP) begin
      fr_d.cnt = CNT_ADDR_END;
    end else begin
      fr_d.cnt = fr_q.cnt + 6'h01;
    end
    if (fr_q.cnt == 6'h00) begin
      cap_d.frameTog = ~cap_q.frameTog;
      cap_d.dataSeen = 1'b0;
    end
    if (fr_q.cnt == CNT_OPCODE_END - 6'h01) begin
      cap_d.opcode = word16[7:0];
    end
    if (fr_q.cnt == CNT_STATUS_END - 6'h01) begin
      cap_d.dataByte = word16[7:0];
    end
    if (fr_q.cnt == CNT_ADDR_END - 6'h01) begin
      cap_d.addr = word16[11:0];
    end
    if (fr_q.cnt == CNT_WRAP_TOP) begin
      cap_d.dataSeen = 1'b1;
    end
    cap_d.lastCnt = fr_d.cnt;
  end

  always_comb begin
    out_d = out_q;
    if (cap_q.opcode == OP_STATUS_READ && fr_q.cnt >= CNT_OPCODE_END) begin
      out_d.soEn = 1'b1;
      if (fr_q.cnt[2:0] == 3'h0) begin
        out_d.snap = fr_q.stSync;
        out_d.so = fr_q.stSync[7];
      end else begin
        out_d.so = out_q.snap[~fr_q.cnt[2:0]];
      end
    end else begin
      out_d.soEn = 1'b0;
      out_d.so = 1'b0;
    end
  end

  always_ff @(posedge sck or posedge frameRst) begin
    if (frameRst) begin
      fr_q <= '0;
    end else begin
      fr_q <= fr_d;
    end
  end

  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      cap_q <= '0;
    end else begin
      cap_q <= cap_d;
    end
  end

  // output changes after falling edges, floats while deselected
  always_ff @(negedge sck or posedge frameRst) begin
    if (frameRst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign so = out_q.so;
  assign soEn = out_q.soEn;
  assign lnk.opcode = cap_q.opcode;
  assign lnk.dataByte = cap_q.dataByte;
  assign lnk.addr = cap_q.addr;
  assign lnk.lastCnt = cap_q.lastCnt;
  assign lnk.dataSeen = cap_q.dataSeen;
  assign lnk.frameTog = cap_q.frameTog;
endmodule

`default_nettype wire

// ==== logic/sep_link_if.sv ====
`default_nettype none

interface sep_link_if;
  logic [7:0] statusWord;
  logic [7:0] opcode;
  logic [7:0] dataByte;
  logic [11:0] addr;
  logic [5:0] lastCnt;
  logic dataSeen;
  logic frameTog;

  modport link (
    input statusWord,
    output opcode,
    output dataByte,
    output addr,
    output lastCnt,
    output dataSeen,
    output frameTog
  );

  modport core (
    output statusWord,
    input opcode,
    input dataByte,
    input addr,
    input lastCnt,
    input dataSeen,
    input frameTog
  );
endinterface

`default_nettype wire

// ==== logic/sep_pkg.sv ====
// Functional notes
// - status byte readable anytime, even while busy
// - status bits: 7 pin enable, 3..2 protect, 1 latch, 0 busy
// - busy flag reads write state, host writes ignored
// - latch bit mirrors latch, not writable by status write
// - latch set and clear commands always act
// - block protect bits changed only by status write
// - protect code selects none, quarter, half, all
// - hardware protect needs pin low and enable bit set
// - hardware protect blocks only nonvolatile status bits
// - pin enable bit written by status write, nonvolatile
// - no array or status write without set latch
// - latch cleared after byte, page or status write
// - array access during write cycle ignored
// - power-up standby, latch clear, output floating
// - latch cleared at power-up and successful write commands
// - all bytes shifted most significant bit first
// - input sampled on rising, output changed on falling edge
`default_nettype none

package sep_pkg;

  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

  localparam int BIT_PIN_PROTECT = 7;
  localparam int BIT_BP_HIGH = 3;
  localparam int BIT_BP_LOW = 2;
  localparam int BIT_LATCH = 1;
  localparam int BIT_BUSY = 0;

  localparam logic [5:0] CNT_OPCODE_END = 6'h08;
  localparam logic [5:0] CNT_STATUS_END = 6'h10;
  localparam logic [5:0] CNT_ADDR_END = 6'h18;
  localparam logic [5:0] CNT_WRAP_TOP = 6'h1F;

  localparam logic [11:0] ADDR_UPPER_QUARTER = 12'hC00;
  localparam logic [11:0] ADDR_UPPER_HALF = 12'h800;

  localparam logic NV_RESET_PIN_PROTECT = 1'b0;
  localparam logic [1:0] NV_RESET_BP = 2'h0;

  localparam int CLK_FREQ_MHZ = 10;
  localparam int WRITE_TIME_US_DEFAULT = 5000;

  typedef enum logic [1:0] {
    SEP_IDLE = 2'b01,
    SEP_BUSY = 2'b10
  } sep_state_e;

  function automatic logic addrProtected(input logic [11:0] a,
                                         input logic [1:0] bp);
    logic r;
    r = 1'b1;
    if (bp == 2'h0) begin
      r = 1'b0;
    end else if (bp == 2'h1) begin
      r = (a >= ADDR_UPPER_QUARTER);
    end else if (bp == 2'h2) begin
      r = (a >= ADDR_UPPER_HALF);
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// ==== logic/sep_status_top.sv ====
`default_nettype none

module sep_status_top #(
  parameter int unsigned WRITE_TIME_US = sep_pkg::WRITE_TIME_US_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic wpN,
  output logic so,
  output logic soEn,
  output logic writeBusy,
  output logic latchState,
  output logic arrayWriteGo,
  output logic [11:0] arrayWriteAddr
);
  import sep_pkg::*;

  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_FREQ_MHZ;

  typedef struct packed {
    logic csMeta;
    logic csSync;
    logic csPrev;
    logic wpMeta;
    logic wpSync;
    logic togSeen;
    sep_state_e st;
    logic latch;
    logic pinProtect;
    logic bpHigh;
    logic bpLow;
    logic pendStatus;
    logic [7:0] pendByte;
    logic [7:0] statusWord;
    logic goPulse;
    logic [11:0] goAddr;
    logic timerStart;
  } sep_sys_s;

  sep_sys_s q, d;
  logic timerDone;
  logic hwProt;
  logic csRise;
  logic frameEnd;
  logic [7:0] sw;

  sep_link_if lnk ();

  sep_link u_link (
    .sck(sck),
    .reset(reset),
    .csN(csN),
    .si(si),
    .so(so),
    .soEn(soEn),
    .lnk(lnk.link)
  );

  sep_cycle_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk(sys_clk),
    .reset(reset),
    .clkEn(clkEn),
    .start(q.timerStart),
    .done(timerDone)
  );

  // hardware protection needs pin low and enable bit set
  assign hwProt = ~q.wpSync & q.pinProtect;
  assign csRise = q.csSync & ~q.csPrev;
  // a select pulse with no clocks leaves the toggle unchanged
  assign frameEnd = csRise & (lnk.frameTog != q.togSeen);

  always_comb begin
    d = q;
    sw = 8'h00;
    if (clkEn) begin
      d.goPulse = 1'b0;
      d.timerStart = 1'b0;
      d.csMeta = csN;
      d.csSync = q.csMeta;
      d.csPrev = q.csSync;
      d.wpMeta = wpN;
      d.wpSync = q.wpMeta;
      if (csRise) begin
        d.togSeen = lnk.frameTog;
      end
      case (q.st)
        SEP_IDLE: begin
          if (frameEnd && q.latch) begin
            if (lnk.opcode == OP_STATUS_WRITE &&
                lnk.lastCnt == CNT_STATUS_END && !hwProt) begin
              d.pendStatus = 1'b1;
              d.pendByte = lnk.dataByte;
              d.timerStart = 1'b1;
              d.st = SEP_BUSY;
            end else if (lnk.opcode == OP_ARRAY_WRITE && lnk.dataSeen &&
                         lnk.lastCnt == CNT_ADDR_END &&
                         !addrProtected(lnk.addr,
                                        {q.bpHigh, q.bpLow})) begin
              d.pendStatus = 1'b0;
              d.goPulse = 1'b1;
              d.goAddr = lnk.addr;
              d.timerStart = 1'b1;
              d.st = SEP_BUSY;
            end
          end
        end
        SEP_BUSY: begin
          // writes arriving now are dropped
          if (timerDone) begin
            if (q.pendStatus) begin
              d.pinProtect = q.pendByte[BIT_PIN_PROTECT];
              d.bpHigh = q.pendByte[BIT_BP_HIGH];
              d.bpLow = q.pendByte[BIT_BP_LOW];
            end
            d.pendStatus = 1'b0;
            d.latch = 1'b0;
            d.st = SEP_IDLE;
          end
        end
        default: begin
          d.st = SEP_IDLE;
        end
      endcase
      // latch commands act regardless of protection or busy
      if (frameEnd && lnk.lastCnt == CNT_OPCODE_END) begin
        if (lnk.opcode == OP_LATCH_SET) begin
          d.latch = 1'b1;
        end else if (lnk.opcode == OP_LATCH_CLEAR) begin
          d.latch = 1'b0;
        end
      end
      sw[BIT_PIN_PROTECT] = d.pinProtect;
      sw[BIT_BP_HIGH] = d.bpHigh;
      sw[BIT_BP_LOW] = d.bpLow;
      sw[BIT_LATCH] = d.latch;
      sw[BIT_BUSY] = (d.st == SEP_BUSY);
      d.statusWord = sw;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.csMeta <= 1'b1;
      q.csSync <= 1'b1;
      q.csPrev <= 1'b1;
      q.wpMeta <= 1'b1;
      q.wpSync <= 1'b1;
      q.st <= SEP_IDLE;
      q.latch <= 1'b0;
      q.pinProtect <= NV_RESET_PIN_PROTECT;
      q.bpHigh <= NV_RESET_BP[1];
      q.bpLow <= NV_RESET_BP[0];
    end else begin
      q <= d;
    end
  end

  assign lnk.statusWord = q.statusWord;
  assign writeBusy = q.statusWord[BIT_BUSY];
  assign latchState = q.statusWord[BIT_LATCH];
  assign arrayWriteGo = q.goPulse;
  assign arrayWriteAddr = q.goAddr;
endmodule

`default_nettype wire

// ==== verif/sep_spi_host.sv ====
`default_nettype none

module sep_spi_host (
  output logic sck,
  output logic csN,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b1;
  end
  task automatic open_frame();
    csN <= 1'b0;
    #20;
  endtask
  // data set while clock low, reply taken at the rising edge
  task automatic bit_x(input logic b, output logic r);
    si <= b;
    #6 sck = 1'b1;
    r = so;
    #6 sck = 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
  endtask
  // deselect right after the last bit, then a long gap
  task automatic close_frame();
    #6 csN <= 1'b1;
    si <= ~si;
    #700;
  endtask
endmodule

`default_nettype wire

// ==== verif/sep_status_checker.sv ====
`default_nettype none

module sep_status_checker #(
  parameter int unsigned WRITE_TIME_US = 5000
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic csN,
  input wire logic soEn,
  input wire logic writeBusy,
  input wire logic latchState,
  input wire logic arrayWriteGo,
  input wire logic [11:0] arrayWriteAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUSY_MAX = WRITE_TIME_US * 10 + 12;
  logic [31:0] busyCnt;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // counts busy cycles, the write time is too long for a delay range
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busyCnt <= 32'h0;
    end else if (writeBusy) begin
      busyCnt <= busyCnt + 32'h1;
    end else begin
      busyCnt <= 32'h0;
    end
  end
  so_float_a: assert property (csN |-> !soEn)
    else $error("output driven while deselected");
  go_latch_a: assert property (arrayWriteGo |-> latchState)
    else $error("write started with latch clear");
  go_pulse_a: assert property (arrayWriteGo |=> !arrayWriteGo)
    else $error("write start longer than a cycle");
  go_idle_a: assert property (arrayWriteGo |-> !$past(writeBusy))
    else $error("write started while busy");
  go_busy_a: assert property (arrayWriteGo |-> ##[0:2] writeBusy)
    else $error("write start without busy");
  busy_span_a: assert property ($rose(writeBusy) |->
    writeBusy [*8])
    else $error("busy length wrong");
  busy_bound_a: assert property (writeBusy |-> busyCnt < BUSY_MAX)
    else $error("busy lasts too long");
  latch_end_a: assert property ($fell(writeBusy) |->
    ##[0:1] !latchState)
    else $error("latch kept after write");
  latch_rise_a: assert property ($rose(latchState) |->
    csN && $past(csN, 2))
    else $error("latch set inside a frame");
  addr_hold_a: assert property ($changed(arrayWriteAddr) |->
    arrayWriteGo)
    else $error("write address moved alone");
  busy_start_a: assert property ($rose(writeBusy) |->
    csN && $past(csN))
    else $error("write cycle began inside a frame");
endmodule

bind sep_status_top sep_status_checker #(
  .WRITE_TIME_US(WRITE_TIME_US)
) u_chk (
  .sys_clk(sys_clk),
  .reset(reset),
  .csN(csN),
  .soEn(soEn),
  .writeBusy(writeBusy),
  .latchState(latchState),
  .arrayWriteGo(arrayWriteGo),
  .arrayWriteAddr(arrayWriteAddr)
);

`default_nettype wire

// ==== verif/tb.sv ====
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic wpN = 1'b1;
  logic sck, csN, si, so, soEn, writeBusy, latchState, arrayWriteGo;
  logic [11:0] arrayWriteAddr, goAddr;
  logic [11:0] edgeA [4] = '{12'hFFF, 12'hC00, 12'h800, 12'h000};
  int fail_count = 0;
  int checks_done = 0;
  int goCnt = 0;
  int cyc = 0;
  always #50 sys_clk = ~sys_clk;
  sep_status_top #(.WRITE_TIME_US(5)) u_dut (.sys_clk(sys_clk),
    .reset(reset), .clkEn(clkEn), .sck(sck), .csN(csN), .si(si),
    .wpN(wpN), .so(so), .soEn(soEn), .writeBusy(writeBusy),
    .latchState(latchState), .arrayWriteGo(arrayWriteGo),
    .arrayWriteAddr(arrayWriteAddr));
  sep_spi_host u_host (.sck(sck), .csN(csN), .si(si), .so(so));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (arrayWriteGo === 1'b1) begin
      goCnt++;
      goAddr = arrayWriteAddr;
    end
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    u_host.open_frame();
    u_host.byte_x(op, r);
    u_host.close_frame();
  endtask
  task automatic stat(input logic [7:0] e);
    logic [7:0] r, s;
    u_host.open_frame();
    u_host.byte_x(8'h05, r);
    u_host.byte_x(8'h00, s);
    u_host.byte_x(8'h00, r);
    check({11'h0, soEn}, 12'h1);
    u_host.close_frame();
    check({11'h0, soEn}, 12'h0);
    check({4'h0, r}, {4'h0, s});
    check({4'h0, s}, {4'h0, e});
  endtask
  task automatic status_write_cmd(input logic [7:0] v);
    logic [7:0] r;
    u_host.open_frame();
    u_host.byte_x(8'h01, r);
    u_host.byte_x(v, r);
    u_host.close_frame();
  endtask
  task automatic awrite(input logic [11:0] a);
    logic [7:0] r;
    cmd(8'h06);
    u_host.open_frame();
    u_host.byte_x(8'h02, r);
    u_host.byte_x({4'hA, a[11:8]}, r);
    u_host.byte_x(a[7:0], r);
    u_host.byte_x(8'h5A, r);
    u_host.close_frame();
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (writeBusy !== 1'b0 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    check({11'h0, writeBusy}, 12'h0);
  endtask
  task automatic t_power();
    check({10'h0, soEn, latchState}, 12'h0);
    stat(8'h00);
    $display("power-up test done");
  endtask
  task automatic t_latch();
    logic [7:0] r;
    logic b;
    cmd(8'h06);
    stat(8'h02);
    cmd(8'h04);
    check({11'h0, latchState}, 12'h0);
    u_host.open_frame();
    u_host.byte_x(8'h06, r);
    u_host.bit_x(1'b0, b);
    u_host.close_frame();
    check({11'h0, latchState}, 12'h0);
    $display("latch test done");
  endtask
  task automatic t_status();
    int g;
    status_write_cmd(8'hFF);
    check({11'h0, writeBusy}, 12'h0);
    cmd(8'h06);
    status_write_cmd(8'hFF);
    stat(8'h03);
    g = goCnt;
    awrite(12'h000);
    check(12'(goCnt - g), 12'h0);
    idle();
    stat(8'h8C);
    $display("status write test done");
  endtask
  task automatic t_hwprot();
    @(posedge sys_clk);
    wpN <= 1'b0;
    cmd(8'h06);
    status_write_cmd(8'h00);
    check({11'h0, writeBusy}, 12'h0);
    stat(8'h8E);
    cmd(8'h04);
    cmd(8'h06);
    check({11'h0, latchState}, 12'h1);
    @(posedge sys_clk);
    wpN <= 1'b1;
    status_write_cmd(8'h00);
    idle();
    stat(8'h00);
    $display("pin protect test done");
  endtask
  task automatic t_blocks();
    logic [11:0] a;
    logic ok;
    int g;
    for (int bp = 0; bp < 4; bp++) begin
      cmd(8'h06);
      status_write_cmd({4'h0, 2'(bp), 2'h0});
      idle();
      for (int k = 0; k < 2; k++) begin
        a = edgeA[bp] - 12'(k);
        ok = (k == 0) ? (bp == 0) : (bp != 3);
        g = goCnt;
        awrite(a);
        check(12'(goCnt - g), {11'h0, ok});
        if (ok) begin
          check(goAddr, a);
          idle();
          check({11'h0, latchState}, 12'h0);
        end else begin
          cmd(8'h04);
        end
      end
    end
    $display("block protect test done");
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_power();
    t_latch();
    t_status();
    t_hwprot();
    t_blocks();
    test_done();
  end
endmodule

`default_nettype wire
